// ---- hdl/plsq_pkg.sv ----
// Constants and types for the power-on and low-power sequencer.
// Assumes a single system clock; slower rates arrive as enable pulses.
package plsq_pkg;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam logic [9:0] PLSQ_POR_CYCLES    = 10'h202; // 514 watchdog RC cycles
  localparam logic [4:0] PLSQ_SETTLE_CYCLES = 5'h10;   // 16 system clock pulses
  localparam logic       PLSQ_POR_FLAG_RST  = 1'h0;
  localparam logic       PLSQ_POR_FLAG_SET  = 1'h1;

  // ---------------------------------------------------------------
  // States and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PLSQ_ST_OFF    = 3'h0,
    PLSQ_ST_POR    = 3'h1,
    PLSQ_ST_SETTLE = 3'h2,
    PLSQ_ST_RUN    = 3'h3,
    PLSQ_ST_HALT   = 3'h4,
    PLSQ_ST_STOP   = 3'h5
  } plsq_state_t;

  // Core requests
  typedef struct packed {
    logic stop_req;
    logic halt_req;
    logic wake_req;
  } plsq_core_req_t;

  // Power and clock controls
  typedef struct packed {
    logic reset_hold;
    logic fetch_vector;
    logic xtal_enable;
    logic sysclk_enable;
    logic core_run;
    logic pc_advance;
    logic periph_enable;
    logic wdt_osc_enable;
    logic wdt_count_enable;
  } plsq_ctrl_t;

endpackage

// ---- hdl/plsq_sync.sv ----
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module plsq_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  import plsq_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } plsq_sync_t;

  plsq_sync_t st_r;
  plsq_sync_t st_nxt;

  // Shift the level along
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule
`default_nettype wire

// ---- hdl/plsq_top.sv ----
// Power-on reset sequencer and low-power mode controller.
// Assumes the watchdog oscillator tick and supply level come from pins,
// core requests come from logic on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module plsq_top (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Pins from analog and oscillator
  input  wire logic                supply_ok,
  input  wire logic                wdt_osc_tick,
  // Core side
  input  wire plsq_pkg::plsq_core_req_t core_req,
  input  wire logic                wdt_enabled,
  input  wire logic                por_flag_clear,
  // Controls and status
  output plsq_pkg::plsq_ctrl_t     ctrl,
  output logic                     por_status_flag,
  output plsq_pkg::plsq_state_t    mode
);
  import plsq_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic supply_s;
  logic tick_s;

  plsq_sync u_sync_supply (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (supply_ok),
    .dout    (supply_s)
  );

  plsq_sync u_sync_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (wdt_osc_tick),
    .dout    (tick_s)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    plsq_state_t state;
    logic [9:0]  por_cnt;
    logic [4:0]  settle_cnt;
    logic        tick_d;
    logic        fetch;
    logic        por_flag;
    plsq_ctrl_t  ctrl;
  } plsq_regs_t;

  plsq_regs_t st_r;
  plsq_regs_t st_nxt;
  logic       tick_edge;

  assign tick_edge = tick_s & ~st_r.tick_d;

  // Next-state logic
  always_comb begin
    st_nxt        = st_r;
    st_nxt.tick_d = tick_s;
    st_nxt.fetch  = 1'b0;
    if (por_flag_clear) begin
      st_nxt.por_flag = PLSQ_POR_FLAG_RST;
    end
    case (st_r.state)
      PLSQ_ST_OFF: begin
        st_nxt.por_cnt    = '0;
        st_nxt.settle_cnt = '0;
        if (supply_s) begin
          st_nxt.state = PLSQ_ST_POR;
        end
      end
      PLSQ_ST_POR: begin
        if (tick_edge) begin
          st_nxt.por_cnt = st_r.por_cnt + 10'h001;
        end
        if (tick_edge && st_r.por_cnt == PLSQ_POR_CYCLES - 10'h001) begin
          st_nxt.state = PLSQ_ST_SETTLE;
        end
      end
      PLSQ_ST_SETTLE: begin
        st_nxt.settle_cnt = st_r.settle_cnt + 5'h01;
        if (st_r.settle_cnt == PLSQ_SETTLE_CYCLES - 5'h01) begin
          st_nxt.state    = PLSQ_ST_RUN;
          st_nxt.fetch    = 1'b1;
          st_nxt.por_flag = PLSQ_POR_FLAG_SET;
        end
      end
      PLSQ_ST_RUN: begin
        if (core_req.stop_req) begin
          st_nxt.state = PLSQ_ST_STOP;
        end else if (core_req.halt_req) begin
          st_nxt.state = PLSQ_ST_HALT;
        end
      end
      PLSQ_ST_HALT: begin
        if (core_req.wake_req) begin
          st_nxt.state = PLSQ_ST_RUN;
        end
      end
      PLSQ_ST_STOP: begin
        if (core_req.wake_req) begin
          st_nxt.state = PLSQ_ST_RUN;
        end
      end
      default: begin
        st_nxt.state = PLSQ_ST_OFF;
      end
    endcase
    // Supply lost during sequencing restarts it
    if (!supply_s && (st_r.state == PLSQ_ST_POR || st_r.state == PLSQ_ST_SETTLE)) begin
      st_nxt.state      = PLSQ_ST_OFF;
      st_nxt.por_cnt    = '0;
      st_nxt.settle_cnt = '0;
      st_nxt.fetch      = 1'b0;
    end
    // Controls registered from the next state
    st_nxt.ctrl.reset_hold     = (st_nxt.state == PLSQ_ST_OFF) || (st_nxt.state == PLSQ_ST_POR)
                               || (st_nxt.state == PLSQ_ST_SETTLE);
    st_nxt.ctrl.fetch_vector   = st_nxt.fetch;
    st_nxt.ctrl.xtal_enable    = (st_nxt.state != PLSQ_ST_STOP);
    st_nxt.ctrl.sysclk_enable  = (st_nxt.state != PLSQ_ST_STOP);
    st_nxt.ctrl.core_run       = (st_nxt.state == PLSQ_ST_RUN);
    st_nxt.ctrl.pc_advance     = (st_nxt.state == PLSQ_ST_RUN);
    st_nxt.ctrl.periph_enable  = (st_nxt.state != PLSQ_ST_STOP) && !st_nxt.ctrl.reset_hold;
    st_nxt.ctrl.wdt_osc_enable = 1'b1;
    st_nxt.ctrl.wdt_count_enable = wdt_enabled && !st_nxt.ctrl.reset_hold;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r                     <= '0;
      st_r.state               <= PLSQ_ST_OFF;
      st_r.por_flag            <= PLSQ_POR_FLAG_RST;
      st_r.ctrl.reset_hold     <= 1'b1;
      st_r.ctrl.xtal_enable    <= 1'b1;
      st_r.ctrl.sysclk_enable  <= 1'b1;
      st_r.ctrl.wdt_osc_enable <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctrl            = st_r.ctrl;
  assign por_status_flag = st_r.por_flag;
  assign mode            = st_r.state;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_reset_hold: assert property (ctrl.reset_hold == (mode inside {PLSQ_ST_OFF, PLSQ_ST_POR, PLSQ_ST_SETTLE}))
    else $error("reset hold does not match sequencer state");
  chk_por_len: assert property ($rose(mode == PLSQ_ST_SETTLE) |-> st_r.por_cnt == PLSQ_POR_CYCLES)
    else $error("power-on count not 514 at settle entry");
  // Settling window is exactly sixteen cycles long
  chk_settle_len: assert property ((mode == PLSQ_ST_SETTLE && supply_s) [*8] ##1
                                   (mode == PLSQ_ST_SETTLE && supply_s) [*8] |=> mode == PLSQ_ST_RUN)
    else $error("settle count not 16 cycles");
  chk_fetch_pulse: assert property ((mode == PLSQ_ST_RUN && $past(mode) == PLSQ_ST_SETTLE) |->
                                    ctrl.fetch_vector ##1 !ctrl.fetch_vector)
    else $error("reset vector fetch not a single pulse");
  chk_flag_set: assert property (($past(mode) == PLSQ_ST_SETTLE && mode == PLSQ_ST_RUN) |-> por_status_flag)
    else $error("power-on flag not set");
  // Flag only drops on a software clear
  chk_flag_sticky: assert property ((por_status_flag && !por_flag_clear) |=> por_status_flag)
    else $error("power-on flag lost without a clear");
  // Core, PC, peripherals and vector fetch stay off while reset is held
  chk_hold_quiet: assert property (ctrl.reset_hold |->
                                   !ctrl.core_run && !ctrl.pc_advance && !ctrl.periph_enable && !ctrl.fetch_vector)
    else $error("core or peripherals active during reset hold");

  // Low-power modes
  chk_stop_entry: assert property ((mode == PLSQ_ST_RUN && core_req.stop_req) |=> mode == PLSQ_ST_STOP)
    else $error("stop request ignored");
  chk_stop_clocks: assert property (mode == PLSQ_ST_STOP |-> !ctrl.xtal_enable && !ctrl.sysclk_enable
                                    && !ctrl.core_run && !ctrl.pc_advance && !ctrl.periph_enable)
    else $error("clocks or core active in stop");
  chk_wdt_osc: assert property (ctrl.wdt_osc_enable)
    else $error("watchdog oscillator disabled");
  chk_wdt_count: assert property (mode == PLSQ_ST_STOP |-> ctrl.wdt_count_enable == $past(wdt_enabled))
    else $error("watchdog count enable wrong in stop");
  chk_stop_exit: assert property ((mode == PLSQ_ST_STOP && !core_req.wake_req) |=> mode == PLSQ_ST_STOP)
    else $error("stop left without recovery");
  chk_halt_clocks: assert property (mode == PLSQ_ST_HALT |-> ctrl.sysclk_enable && ctrl.xtal_enable
                                    && !ctrl.pc_advance)
    else $error("halt state controls wrong");
  chk_halt_exit: assert property ((mode == PLSQ_ST_HALT && !core_req.wake_req) |=> mode == PLSQ_ST_HALT)
    else $error("halt left without a wake request");
  // A supply drop while sequencing throws the count away
  chk_supply_drop: assert property ((mode inside {PLSQ_ST_POR, PLSQ_ST_SETTLE} && !supply_s) |=>
                                    mode == PLSQ_ST_OFF && st_r.por_cnt == 10'h000)
    else $error("supply drop did not restart sequence");

  // Scenario coverage
  cov_por_done: cover property (mode == PLSQ_ST_SETTLE ##[1:20] mode == PLSQ_ST_RUN);
  cov_flag_clear: cover property (por_status_flag ##1 !por_status_flag);
  cov_stop_wake: cover property (mode == PLSQ_ST_STOP ##[1:50] mode == PLSQ_ST_RUN);
  cov_halt: cover property (mode == PLSQ_ST_HALT);
  cov_restart: cover property (mode == PLSQ_ST_POR ##1 mode == PLSQ_ST_OFF);
endmodule
`default_nettype wire

// ---- sim/plsq_partner.sv ----
// Watchdog RC oscillator and supply monitor model.
// Assumes the bench drives power_up; the tick runs free.
`timescale 1ns/100ps
`default_nettype none
module plsq_partner (
  // Clock
  input  wire logic clk_sys,
  // Supply request and outputs
  input  wire logic power_up,
  output logic      supply_ok,
  output logic      wdt_osc_tick
);
  logic [2:0] ph_r = 3'h0;
  // Free running phase, three cycles high then three low
  always @(posedge clk_sys) begin
    ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
  end
  assign wdt_osc_tick = (ph_r < 3'h3);
  // Threshold follows the bench request
  assign supply_ok = power_up;
endmodule
`default_nettype wire

// ---- sim/plsq_top_test.sv ----
// Self-checking bench for the power-on and low-power sequencer.
// Assumes plsq_pkg, plsq_top and plsq_partner compiled first.
`timescale 1ns/100ps
`default_nettype none
module plsq_top_test;
  import plsq_pkg::*;
  // --------
  // Signals
  // --------
  typedef struct packed {
    plsq_state_t st;
    logic [8:0]  mk;
    logic [8:0]  ct;
    logic        fl;
    logic [15:0] lo;
    logic [15:0] hi;
  } plsq_note_t;
  logic           clk_sys = 1'h0;
  logic           rst = 1'h1;
  logic           power_up = 1'h0;
  logic           supply_ok;
  logic           wdt_osc_tick;
  plsq_core_req_t core_req = '0;
  logic           wdt_enabled = 1'h0;
  logic           por_flag_clear = 1'h0;
  plsq_ctrl_t     ctrl;
  logic           por_status_flag;
  plsq_state_t    mode;
  plsq_state_t    pm;
  logic           pf;
  plsq_note_t     q[$];
  plsq_note_t     n;
  int             err_total = 0;
  int             num_checks = 0;
  int             cyc = 0;
  int             lc = 0;
  int             seed = 34;
  int             i;
  plsq_partner u_plsq_partner (.clk_sys(clk_sys), .power_up(power_up), .supply_ok(supply_ok),
    .wdt_osc_tick(wdt_osc_tick));
  plsq_top u_plsq_top (.clk_sys(clk_sys), .rst(rst), .supply_ok(supply_ok), .wdt_osc_tick(wdt_osc_tick),
    .core_req(core_req), .wdt_enabled(wdt_enabled), .por_flag_clear(por_flag_clear), .ctrl(ctrl),
    .por_status_flag(por_status_flag), .mode(mode));
  // Clock
  always #5 clk_sys = ~clk_sys;
  // --------
  // Helpers
  // --------
  // Bits: hold fetch xtal sysclk core pc periph osc count
  function automatic logic [8:0] exp_ctrl(plsq_state_t s, logic fv, logic we);
    case (s)
      PLSQ_ST_RUN:  return {1'h0, fv, 6'h3F, we};
      PLSQ_ST_HALT: return {2'h0, 6'h31, we};
      PLSQ_ST_STOP: return {2'h0, 6'h01, we};
      default:      return {2'h2, 6'h31, 1'h0};
    endcase
  endfunction
  task automatic note(plsq_state_t s, logic fv = 1'h0, logic fl = 1'h0, logic [15:0] lo = 16'h0,
                      logic [15:0] hi = 16'hFFFF);
    q.push_back('{s, (s == PLSQ_ST_HALT) ? 9'h1FB : 9'h1FF, exp_ctrl(s, fv, wdt_enabled), fl, lo, hi});
  endtask
  task automatic cmp(string nm, logic [8:0] e, logic [8:0] s);
    num_checks++;
    if (e !== s) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pulse(plsq_core_req_t r);
    core_req <= r;
    @(posedge clk_sys);
    core_req <= '0;
    @(posedge clk_sys);
  endtask
  // Supply rises one cycle into a tick high phase
  task automatic raise();
    @(posedge wdt_osc_tick);
    @(posedge clk_sys);
    power_up <= 1'h1;
  endtask
  task automatic report_and_stop();
    cmp("pending", 9'h0, 9'(q.size()));
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // --------
  // Monitor
  // --------
  // Each mode or flag change takes the oldest note
  always @(negedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc > 8000) begin
      err_total++;
      report_and_stop();
    end
    if (!rst && {mode, por_status_flag} !== {pm, pf}) begin
      if (q.size() == 0) cmp("change", 9'h0, 9'h1);
      else begin
        n = q.pop_front();
        cmp("mode", 9'(n.st), 9'(mode));
        cmp("ctrl", n.ct & n.mk, 9'(ctrl) & n.mk);
        cmp("flag", 9'(n.fl), 9'(por_status_flag));
        cmp("time", 9'(cyc - lc >= n.lo && cyc - lc <= n.hi), 9'h1);
      end
      lc = cyc;
    end
    pm = mode;
    pf = por_status_flag;
  end
  // --------
  // Stimulus
  // --------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    note(PLSQ_ST_POR);
    raise();
    repeat (100) @(posedge clk_sys);
    note(PLSQ_ST_OFF);
    power_up <= 1'h0;
    repeat (20) @(posedge clk_sys);
    note(PLSQ_ST_POR);
    note(PLSQ_ST_SETTLE, 1'h0, 1'h0, 16'hC08, 16'hC0E);
    note(PLSQ_ST_RUN, 1'h1, 1'h1, 16'h10, 16'h10);
    raise();
    for (int k = 0; k < 4000 && mode !== PLSQ_ST_RUN; k++) @(posedge clk_sys);
    pulse(3'h1);
    note(PLSQ_ST_RUN);
    por_flag_clear <= 1'h1;
    @(posedge clk_sys);
    por_flag_clear <= 1'h0;
    for (i = 0; i < 4; i++) begin
      wdt_enabled <= 1'($random(seed));
      repeat (3) @(posedge clk_sys);
      note((i % 2) ? PLSQ_ST_HALT : PLSQ_ST_STOP);
      pulse((i % 2) ? 3'h2 : (i == 2) ? 3'h6 : 3'h4);
      repeat (5 + $unsigned($random(seed)) % 16) @(posedge clk_sys);
      pulse(3'h6);
      note(PLSQ_ST_RUN);
      pulse(3'h1);
    end
    repeat (3) @(posedge clk_sys);
    report_and_stop();
  end
endmodule
`default_nettype wire
